// [logic/urb_pkg.sv]
package urb_pkg;

  // ---------------------------------------------------------------------
  // Register map (byte addresses on APB)
  // ---------------------------------------------------------------------
  localparam int          ADDR_W    = 8;
  localparam logic [7:0]  REG_RCS   = 8'h00; // receive_control_status
  localparam logic [7:0]  REG_TCS   = 8'h04; // transmit_control_status
  localparam logic [7:0]  REG_DIV   = 8'h08; // baud_divisor
  localparam logic [7:0]  REG_BUF   = 8'h0C; // receive_buffer
  localparam logic [7:0]  REG_IST   = 8'h10; // Interrupt status, W1C
  localparam logic [7:0]  REG_IMSK  = 8'h14; // Interrupt mask

  // ---------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------
  localparam int          RCS_PORT_EN = 7;
  localparam int          RCS_NINE    = 6;
  localparam int          RCS_SINGLE  = 5;
  localparam int          RCS_CONT    = 4;
  localparam int          RCS_ADDR    = 3;
  localparam logic [7:0]  RCS_WMASK   = 8'hF8;
  localparam int          TCS_MASTER  = 7;
  localparam int          TCS_SYNC    = 4;
  localparam int          TCS_HIGH    = 2;
  localparam logic [7:0]  TCS_WMASK   = 8'h94;
  localparam logic [7:0]  RST_BYTE    = 8'h00;
  localparam logic [31:0] RST_WORD    = 32'h0000_0000;
  localparam logic [23:0] PAD_HI      = 24'h00_0000;

  // Interrupt status bits
  localparam int          IRQ_W       = 3;
  localparam int          IRQ_RX      = 0;
  localparam int          IRQ_FRAMING_ERROR_FLAG    = 1;
  localparam int          IRQ_OVERRUN_ERROR_FLAG    = 2;
  localparam logic [2:0]  IRQ_NONE    = 3'h0;

  // ---------------------------------------------------------------------
  // Baud generator prescale limits (timer periods per tick, minus one)
  // ---------------------------------------------------------------------
  localparam logic [1:0]  PRE_ASYNC_LOW  = 2'h3; // 4 x 16 = 64
  localparam logic [1:0]  PRE_ASYNC_HIGH = 2'h0; // 1 x 16 = 16
  localparam logic [1:0]  PRE_SYNC       = 2'h1; // 2 half periods = 4
  localparam logic [1:0]  PRE_ZERO       = 2'h0;

  // Receiver timing, in oversample ticks and in data bits
  localparam logic [3:0]  OS_VOTE   = 4'h9;
  localparam logic [3:0]  OS_LAST   = 4'hF;
  localparam logic [3:0]  CNT_ZERO  = 4'h0;
  localparam logic [3:0]  LAST_8BIT = 4'h7;
  localparam logic [3:0]  LAST_9BIT = 4'h8;

  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_STOP,
    RX_SYNC
  } urb_rx_state_t;

endpackage

// [logic/urb_baud_gen.sv]
`timescale 1ns/1ps

module urb_baud_gen (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [7:0] divisor,
  input  wire logic       div_write,
  input  wire logic       sync_mode,
  input  wire logic       high_speed,
  output logic            os_tick,
  output logic            sync_half
);
  import urb_pkg::*;

  logic [7:0] timer;
  logic [1:0] pre;

  // ---------------------------------------------------------------------
  // Period selection
  // ---------------------------------------------------------------------
  // Sync mode looks at the divisor alone, so high speed is not consulted
  wire       wrap    = (timer == divisor);
  wire [1:0] pre_lim = sync_mode  ? PRE_SYNC :
                       high_speed ? PRE_ASYNC_HIGH : PRE_ASYNC_LOW;
  // Restart on >= so a mode change mid-count cannot overshoot, but tick
  // only on an exact match: a stale count gives one quiet restart
  wire       pre_end = (pre >= pre_lim);
  wire       tick    = wrap & (pre == pre_lim);

  assign os_tick   = tick & ~sync_mode;
  assign sync_half = tick & sync_mode;

  // ---------------------------------------------------------------------
  // Free running timer, restarted on a divisor write
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst || div_write) begin
      timer <= RST_BYTE;
      pre   <= PRE_ZERO;
    end else if (wrap) begin
      timer <= RST_BYTE;
      pre   <= pre_end ? PRE_ZERO : pre + 2'h1;
    end else begin
      timer <= timer + 8'h01;
    end
  end

  a_timer_restart: assert property (@(posedge clk) disable iff (!nrst)
    div_write |=> (timer == RST_BYTE) && (pre == PRE_ZERO))
    else $error("timer not cleared after divisor write");
  a_tick_on_wrap: assert property (@(posedge clk) disable iff (!nrst)
    tick |=> timer == RST_BYTE || $past(div_write))
    else $error("timer did not restart after tick");
  a_sync_prescale: assert property (@(posedge clk) disable iff (!nrst)
    sync_half |-> pre == PRE_SYNC)
    else $error("sync half period not two timer periods");
  a_low_prescale: assert property (@(posedge clk) disable iff (!nrst)
    (os_tick && !high_speed) |-> pre == PRE_ASYNC_LOW)
    else $error("low speed tick not four timer periods");

endmodule

// [logic/urb_rx_ctrl.sv]
`timescale 1ns/1ps

// Contract
// - An 8-bit free running timer, period set by the baud divisor, serves both modes.
// - In async mode the high speed select changes the rate as well as the divisor.
// - In sync mode the high speed select is ignored.
// - The divisor rate drives the clock only as sync master; a slave takes the clock from outside.
// - Writing the baud divisor clears the baud timer at once.
// - The receive pin is sampled three times per bit and the level taken by majority.
// - Rates are Fosc/(64(X+1)) async low, Fosc/(16(X+1)) async high, Fosc/(4(X+1)) sync.
module urb_rx_ctrl (
  input  wire logic                       clk,
  input  wire logic                       nrst,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [urb_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata,
  output logic                            pready,
  output logic                            pslverr,
  output logic                            irq,
  input  wire logic                       rx_in,
  input  wire logic                       ck_in,
  output logic                            ck_out,
  output logic                            ck_oe
);
  import urb_pkg::*;

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] off);
    hit = (a == off);
  endfunction

  function automatic logic majority(input logic [2:0] s);
    majority = (s[0] & s[1]) | (s[0] & s[2]) | (s[1] & s[2]);
  endfunction

  logic [7:0]        rcs_ctrl;
  logic [7:0]        tcs;
  logic [7:0]        divisor;
  logic [7:0]        buf_data;
  logic              buf_full;
  logic              framing_error_flag;
  logic              overrun_error_flag;
  logic              received_ninth_bit;
  logic [IRQ_W-1:0]  ist;
  logic [IRQ_W-1:0]  imsk;
  logic [2:0]        samp;
  logic [8:0]        shreg;
  logic [3:0]        os_cnt;
  logic [3:0]        bit_cnt;
  logic              ck_prev;
  urb_rx_state_t     state;
  logic              os_tick;
  logic              sync_half;

  // ---------------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------------
  // One wait state: pready rises on the second access cycle
  wire acc     = psel & penable & ~pready;
  wire take    = psel & penable & pready;
  wire wr      = take & pwrite;
  wire rd      = take & ~pwrite;
  wire mapped  = hit(paddr, REG_RCS) | hit(paddr, REG_TCS) |
                 hit(paddr, REG_DIV) | hit(paddr, REG_BUF) |
                 hit(paddr, REG_IST) | hit(paddr, REG_IMSK);
  wire wr_rcs  = wr & hit(paddr, REG_RCS);
  wire wr_tcs  = wr & hit(paddr, REG_TCS);
  wire wr_div  = wr & hit(paddr, REG_DIV);
  wire wr_ist  = wr & hit(paddr, REG_IST);
  wire wr_imsk = wr & hit(paddr, REG_IMSK);
  wire buf_rd  = rd & hit(paddr, REG_BUF);

  // Control fields
  wire port_en   = rcs_ctrl[RCS_PORT_EN];
  wire nine_bit  = rcs_ctrl[RCS_NINE];
  wire single_en = rcs_ctrl[RCS_SINGLE];
  wire cont_en   = rcs_ctrl[RCS_CONT];
  wire addr_det  = rcs_ctrl[RCS_ADDR];
  wire master    = tcs[TCS_MASTER];
  wire sync_mode = tcs[TCS_SYNC];
  wire high_spd  = tcs[TCS_HIGH];

  // Read mux; status bits are read only
  wire [7:0] rcs_rd = {rcs_ctrl[RCS_PORT_EN:RCS_ADDR], framing_error_flag, overrun_error_flag, received_ninth_bit};
  wire [7:0] rd_val = hit(paddr, REG_RCS)  ? rcs_rd :
                      hit(paddr, REG_TCS)  ? tcs :
                      hit(paddr, REG_DIV)  ? divisor :
                      hit(paddr, REG_BUF)  ? buf_data :
                      hit(paddr, REG_IST)  ? {5'h00, ist} :
                      hit(paddr, REG_IMSK) ? {5'h00, imsk} : RST_BYTE;

  // ---------------------------------------------------------------------
  // Baud generator
  // ---------------------------------------------------------------------
  urb_baud_gen u_baud (
    .clk       (clk),
    .nrst      (nrst),
    .divisor   (divisor),
    .div_write (wr_div),
    .sync_mode (sync_mode),
    .high_speed(high_spd),
    .os_tick   (os_tick),
    .sync_half (sync_half)
  );

  // ---------------------------------------------------------------------
  // Receive datapath decode
  // ---------------------------------------------------------------------
  // Overrun halts the receiver until software clears continuous receive
  wire rx_en_async = port_en & cont_en & ~sync_mode & ~overrun_error_flag;
  wire rx_en_sync  = port_en & (cont_en | single_en) & sync_mode & ~overrun_error_flag;
  wire vote        = majority(samp);
  wire samp_en     = sync_mode | os_tick;
  wire [3:0] last  = nine_bit ? LAST_9BIT : LAST_8BIT;
  wire at_vote     = os_tick & (os_cnt == OS_VOTE);
  wire at_end      = os_tick & (os_cnt == OS_LAST);
  // Master falls on its own toggle; slave watches the external clock
  wire ck_fall     = master ? (sync_half & ck_out & rx_en_sync)
                            : (ck_prev & ~ck_in);

  wire [8:0] shift_in = {vote, shreg[8:1]};
  wire [8:0] word_src = (state == RX_SYNC) ? shift_in : shreg;
  wire [8:0] word     = nine_bit ? word_src : {1'b0, word_src[8:1]};
  wire done_async     = (state == RX_STOP) & at_vote;
  wire done_sync      = (state == RX_SYNC) & ck_fall & (bit_cnt == last);
  wire done           = done_async | done_sync;
  wire frame_bad      = done_async & ~vote;
  wire addr_drop      = addr_det & nine_bit & ~word[8] & ~sync_mode;
  wire overrun        = done & buf_full;
  wire accept         = done & ~buf_full & ~addr_drop;
  wire [IRQ_W-1:0] ev = {overrun, accept & frame_bad, accept};

  // ---------------------------------------------------------------------
  // APB answer
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= RST_WORD;
    end else begin
      pready  <= acc;
      pslverr <= acc & ~mapped;
      prdata  <= acc ? {PAD_HI, rd_val} : prdata;
    end
  end

  // ---------------------------------------------------------------------
  // Software registers
  // ---------------------------------------------------------------------
  // Single receive self clears after one sync word unless continuous
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rcs_ctrl <= RST_BYTE;
      tcs      <= RST_BYTE;
      divisor  <= RST_BYTE;
      imsk     <= IRQ_NONE;
    end else begin
      if (wr_rcs)
        rcs_ctrl <= pwdata[7:0] & RCS_WMASK;
      else if (done_sync && !cont_en)
        rcs_ctrl[RCS_SINGLE] <= 1'b0;
      if (wr_tcs)
        tcs <= pwdata[7:0] & TCS_WMASK;
      if (wr_div)
        divisor <= pwdata[7:0];
      if (wr_imsk)
        imsk <= pwdata[IRQ_W-1:0];
    end
  end

  // ---------------------------------------------------------------------
  // Receive buffer, error flags, interrupt
  // ---------------------------------------------------------------------
  // Hardware sets win over a clear in the same cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      buf_data <= RST_BYTE;
      buf_full <= 1'b0;
      framing_error_flag     <= 1'b0;
      overrun_error_flag     <= 1'b0;
      received_ninth_bit     <= 1'b0;
      ist      <= IRQ_NONE;
      irq      <= 1'b0;
    end else begin
      if (accept) begin
        buf_data <= word[7:0];
        received_ninth_bit     <= word[8];
        framing_error_flag     <= frame_bad;
      end
      buf_full <= accept | (buf_full & ~buf_rd);
      overrun_error_flag     <= overrun |
                  (overrun_error_flag & ~(wr_rcs & ~pwdata[RCS_CONT]));
      ist      <= ev | (ist & ~({IRQ_W{wr_ist}} & pwdata[IRQ_W-1:0]));
      irq      <= |(ist & imsk);
    end
  end

  // ---------------------------------------------------------------------
  // Pin sampling and sync clock
  // ---------------------------------------------------------------------
  // Async takes three successive oversample ticks around mid bit
  always_ff @(posedge clk) begin
    if (!nrst) begin
      samp    <= 3'h7;
      ck_prev <= 1'b0;
      ck_out  <= 1'b0;
      ck_oe   <= 1'b0;
    end else begin
      if (samp_en)
        samp <= {samp[1:0], rx_in};
      ck_prev <= ck_in;
      if (master && rx_en_sync && sync_half)
        ck_out <= ~ck_out;
      else if (!(master && rx_en_sync))
        ck_out <= 1'b0;
      ck_oe <= port_en & sync_mode & master;
    end
  end

  // ---------------------------------------------------------------------
  // Receive sequencer
  // ---------------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (!nrst) begin
      state   <= RX_IDLE;
      os_cnt  <= CNT_ZERO;
      bit_cnt <= CNT_ZERO;
      shreg   <= 9'h000;
    end else begin
      if (os_tick)
        os_cnt <= os_cnt + 4'h1;
      unique case (state)
        RX_IDLE: begin
          os_cnt  <= CNT_ZERO;
          bit_cnt <= CNT_ZERO;
          if (rx_en_sync)
            state <= RX_SYNC;
          else if (rx_en_async && os_tick && !rx_in)
            state <= RX_START;
        end
        RX_START: begin
          if (!rx_en_async || (at_vote && vote))
            state <= RX_IDLE;  // False start is dropped
          else if (at_end)
            state <= RX_DATA;
        end
        RX_DATA: begin
          if (!rx_en_async)
            state <= RX_IDLE;
          else if (at_vote)
            shreg <= shift_in;
          else if (at_end) begin
            bit_cnt <= bit_cnt + 4'h1;
            if (bit_cnt == last)
              state <= RX_STOP;
          end
        end
        RX_STOP: begin
          if (!rx_en_async || at_vote)
            state <= RX_IDLE;
        end
        RX_SYNC: begin
          // Continuous enable keeps this state across words
          if (!rx_en_sync)
            state <= RX_IDLE;
          else if (ck_fall) begin
            shreg   <= shift_in;
            bit_cnt <= (bit_cnt == last) ? CNT_ZERO : bit_cnt + 4'h1;
          end
        end
      endcase
    end
  end

  a_vote_shift: assert property (@(posedge clk) disable iff (!nrst)
    (state == RX_DATA && rx_en_async && at_vote) |=> shreg[8] == $past(vote))
    else $error("data bit not taken from majority vote");
  a_overrun_error_flag_clear: assert property (@(posedge clk) disable iff (!nrst)
    (wr_rcs && !pwdata[RCS_CONT] && !overrun) |=> !overrun_error_flag)
    else $error("overrun not cleared with continuous receive");
  a_slave_no_drive: assert property (@(posedge clk) disable iff (!nrst)
    (!master || !sync_mode) |=> !ck_oe && !ck_out)
    else $error("clock pin driven while not sync master");
  a_cont_keeps: assert property (@(posedge clk) disable iff (!nrst)
    (done_sync && cont_en && !wr_rcs) |=> rcs_ctrl[RCS_SINGLE] ==
      $past(rcs_ctrl[RCS_SINGLE]))
    else $error("single enable changed under continuous receive");
  a_irq_level: assert property (@(posedge clk) disable iff (!nrst)
    ##1 irq == |($past(ist) & $past(imsk)))
    else $error("interrupt not following masked status");

endmodule

// [bench/urb_peer.sv]
`timescale 1ns/1ps

// ---------------------------------------------------------------------
// Serial peer: async terminal or sync peripheral on the receive pin
// ---------------------------------------------------------------------
module urb_peer (
  input  wire logic clk,
  input  wire logic ck_master,
  output logic      rx_line,
  output logic      ck_line
);

  // Line idles high, external bit clock stands still low
  initial begin
    rx_line = 1'b1;
    ck_line = 1'b0;
  end

  // Async frame: start, 8 data LSB first, stop; optional one-clock spike mid every bit
  task automatic send_async(input logic [7:0] data, input int bit_clks,
                            input logic stop_bit, input logic glitch);
    logic [9:0] frame;
    frame = {stop_bit, data, 1'b0};
    for (int b = 0; b < 10; b++) begin
      for (int c = 0; c < bit_clks; c++) begin
        @(posedge clk);
        rx_line <= (glitch && c == bit_clks / 2) ? ~frame[b] : frame[b];
      end
    end
    @(posedge clk);
    rx_line <= 1'b1;
  endtask

  // Sync word; data moves after each falling bit clock edge
  task automatic send_sync(input logic [7:0] data, input logic slave);
    for (int b = 0; b < 8; b++) begin
      @(posedge clk);
      rx_line <= data[b];
      if (slave) begin
        ck_line <= 1'b1;
        repeat (4) @(posedge clk);
        ck_line <= 1'b0;
        repeat (4) @(posedge clk);
      end else begin
        wait (ck_master === 1'b1);
        wait (ck_master === 1'b0);
      end
    end
    @(posedge clk);
    rx_line <= ~data[7]; // Released line must not look like held data
  endtask

endmodule

// [bench/tb_top.sv]
`timescale 1ns/1ps

module tb_top;
  import urb_pkg::*;

  localparam int LIMIT = 40000;

  logic        clk;
  logic        nrst;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        irq;
  logic        rx_in;
  logic        ck_in;
  logic        ck_out;
  logic        ck_oe;
  logic [31:0] rd;
  logic        err;
  int          mismatches;
  int          check_count;
  int          cycles;
  int          n;

  urb_rx_ctrl u_urb_rx_ctrl (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq),
    .rx_in(rx_in), .ck_in(ck_in), .ck_out(ck_out), .ck_oe(ck_oe));

  urb_peer u_urb_peer (.clk(clk), .ck_master(ck_out), .rx_line(rx_in),
    .ck_line(ck_in));

  // 100 ns clock
  always #50 clk = ~clk;

  // Hang guard: a stuck wait ends as a mismatch
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == LIMIT) begin
      mismatches++;
      close_out();
    end
  end

  // ---------------------------------------------------------------------
  // Compare and bus tasks
  // ---------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string what);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic chk1(input logic got, input logic exp, input string what);
    chk({31'h0000_0000, got}, {31'h0000_0000, exp}, what);
  endtask

  // One APB access plus an idle cycle, so no signal is set twice per step
  task automatic xfer(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    xfer(a, 1'b1, {24'h00_0000, d});
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e);
    xfer(a, 1'b0, 32'h0000_0000);
    chk(rd, {24'h00_0000, e}, "read data");
    chk1(err, 1'b0, "slave error");
  endtask

  // Wait for a word, check status and data, clear and see irq drop
  task automatic got_byte(input logic [7:0] e, input logic [7:0] st);
    do @(posedge clk); while (irq !== 1'b1);
    rdc(REG_IST, st);
    rdc(REG_BUF, e);
    wr(REG_IST, st);
    @(posedge clk);
    chk1(irq, 1'b0, "irq after clear");
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------
  task automatic t_regs();
    for (int i = 0; i < 6; i++) begin
      rdc(8'(4 * i), 8'h00);
    end
    xfer(8'h18, 1'b0, 32'h0000_0000);
    chk(rd, 32'h0000_0000, "unmapped data");
    chk1(err, 1'b1, "unmapped error");
    wr(REG_TCS, 8'hFF);
    rdc(REG_TCS, 8'h94);
    wr(REG_RCS, 8'h6F);
    rdc(REG_RCS, 8'h68);
    wr(REG_RCS, 8'h00);
    wr(REG_DIV, 8'hA5);
    rdc(REG_DIV, 8'hA5);
  endtask

  // High speed, divisor 1: 32 clocks a bit; port enable and mask first
  task automatic t_async_high();
    wr(REG_TCS, 8'h04);
    wr(REG_DIV, 8'h01);
    wr(REG_RCS, 8'h10);
    u_urb_peer.send_async(8'hA5, 32, 1'b1, 1'b0);
    rdc(REG_IST, 8'h00);
    wr(REG_RCS, 8'h90);
    u_urb_peer.send_async(8'hA5, 32, 1'b1, 1'b0);
    rdc(REG_IST, 8'h01);
    chk1(irq, 1'b0, "masked irq");
    wr(REG_IMSK, 8'h07);
    got_byte(8'hA5, 8'h01);
  endtask

  // Low speed, divisor 0: 64 clocks a bit; then spike, framing, overrun
  task automatic t_async_more();
    wr(REG_TCS, 8'h00);
    wr(REG_DIV, 8'h00);
    fork
      u_urb_peer.send_async(8'h3C, 64, 1'b1, 1'b0);
      got_byte(8'h3C, 8'h01);
    join
    wr(REG_TCS, 8'h04);
    fork
      u_urb_peer.send_async(8'h5A, 16, 1'b1, 1'b1);
      got_byte(8'h5A, 8'h01);
    join
    fork
      u_urb_peer.send_async(8'h81, 16, 1'b0, 1'b0);
      got_byte(8'h81, 8'h03);
    join
    rdc(REG_RCS, 8'h94);
    u_urb_peer.send_async(8'h11, 16, 1'b1, 1'b0);
    u_urb_peer.send_async(8'h22, 16, 1'b1, 1'b0);
    rdc(REG_IST, 8'h05);
    rdc(REG_RCS, 8'h92);
    wr(REG_RCS, 8'h96);
    rdc(REG_RCS, 8'h92);
    rdc(REG_BUF, 8'h11);
    wr(REG_RCS, 8'h80);
    rdc(REG_RCS, 8'h80);
    wr(REG_IST, 8'h07);
  endtask

  // Sync master: divisor restart, bit clock period, continuous receive
  task automatic t_sync_master();
    wr(REG_TCS, 8'h94);
    wr(REG_DIV, 8'hC8);
    wr(REG_RCS, 8'h90);
    @(posedge clk);
    chk1(ck_oe, 1'b1, "master drives clock");
    do @(posedge clk); while (ck_out !== 1'b1);
    repeat (100) @(posedge clk);
    wr(REG_DIV, 8'h01);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ck_out === 1'b1);
    chk(32'(n <= 5), 32'h0000_0001, "divisor restart");
    wr(REG_RCS, 8'h80);
    wr(REG_DIV, 8'h02);
    xfer(REG_BUF, 1'b0, 32'h0000_0000);
    wr(REG_IST, 8'h07);
    fork
      begin
        u_urb_peer.send_sync(8'hC3, 1'b0);
        u_urb_peer.send_sync(8'h3C, 1'b0);
      end
      begin
        wr(REG_RCS, 8'h90);
        got_byte(8'hC3, 8'h01);
        got_byte(8'h3C, 8'h01);
      end
    join
    do @(posedge clk); while (ck_out !== 1'b1);
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ck_out !== 1'b0);
    do begin
      @(posedge clk);
      n++;
    end while (ck_out !== 1'b1);
    chk(32'(n), 32'h0000_000C, "sync clock period");
    wr(REG_RCS, 8'h80);
    xfer(REG_BUF, 1'b0, 32'h0000_0000);
    wr(REG_IST, 8'h07);
  endtask

  // Sync slave: bit clock from the peer, own clock output quiet
  task automatic t_sync_slave();
    wr(REG_TCS, 8'h10);
    fork
      u_urb_peer.send_sync(8'h69, 1'b1);
      begin
        wr(REG_RCS, 8'h90);
        chk1(ck_oe, 1'b0, "slave clock enable");
        got_byte(8'h69, 8'h01);
      end
    join
    chk1(ck_out, 1'b0, "slave clock output");
  endtask

  // Main sequence
  initial begin
    clk = 1'b0;
    nrst = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    mismatches = 0;
    check_count = 0;
    cycles = 0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    t_regs();
    t_async_high();
    t_async_more();
    t_sync_master();
    t_sync_slave();
    close_out();
  end

endmodule
